/* File: shared/mb_pkg.sv */
package mb_pkg;

	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_DIAG = 8'h08;
	localparam logic [7:0] FC_WRMULTI = 8'h10;
	localparam logic [7:0] FC_LOG = 8'h46;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [15:0] SUB_ECHO = 16'h0000;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_DATA = 8'h03;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [15:0] MAX_REGS = 16'h007D;
	localparam logic [7:0] BC_MIN = 8'h02;
	localparam logic [7:0] BC_MAX = 8'hFA;
	localparam logic [16:0] REG_BASE = 17'h09C41;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [8:0] MIN_FRAME = 9'h004;
	localparam logic [8:0] DIAG_LEN = 9'h008;
	localparam logic [8:0] LOG_LEN = 9'h004;
	localparam logic [8:0] WR_HDR_LEN = 9'h009;
	localparam logic [2:0] BODY_LEN = 3'h6;
	localparam logic [2:0] EXC_LEN = 3'h3;

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] x;
		x = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction

endpackage

/* File: shared/mb_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mb_link_if;
	logic q_valid;
	logic [7:0] q_data;
	logic q_last;
	logic q_ready;
	logic r_valid;
	logic [7:0] r_data;
	logic r_last;
	logic r_ready;

	modport master_mp (
		output q_valid, q_data, q_last, r_ready,
		input q_ready, r_valid, r_data, r_last
	);
	modport slave_mp (
		input q_valid, q_data, q_last, r_ready,
		output q_ready, r_valid, r_data, r_last
	);
endinterface
`default_nettype wire

/* File: src/mb_master_end.sv */
`timescale 1ns/1ps
`default_nettype none
module mb_master_end (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	mb_link_if.master_mp link,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	output logic o_query_bad,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_last,
	output logic o_rx_crc_ok
);

	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_SEND = 2'b01,
		M_CRC_LO = 2'b10,
		M_CRC_HI = 2'b11
	} mstate_t;

	mstate_t state_q;
	logic [7:0] data_q;
	logic last_q;
	logic [15:0] crc_q;
	logic [15:0] rcrc_q;
	logic [3:0] idx_q;
	logic [7:0] addr_q;
	logic [7:0] fc_q;
	logic [15:0] cnt_q;

	assign o_tx_ready = (state_q == M_IDLE);
	assign link.q_valid = (state_q != M_IDLE);
	assign link.q_data = (state_q == M_SEND) ? data_q :
		(state_q == M_CRC_LO) ? crc_q[7:0] : crc_q[15:8];
	assign link.q_last = (state_q == M_CRC_HI);
	assign link.r_ready = 1'b1;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_q <= M_IDLE;
			data_q <= 8'h00;
			last_q <= 1'b0;
			crc_q <= mb_pkg::CRC_INIT;
		end else begin
			case (state_q)
				M_IDLE: begin
					if (i_tx_valid) begin
						data_q <= i_tx_data;
						last_q <= i_tx_last;
						state_q <= M_SEND;
					end
				end
				M_SEND: begin
					if (link.q_ready) begin
						crc_q <= mb_pkg::crc_step(crc_q, data_q);
						state_q <= last_q ? M_CRC_LO : M_IDLE;
					end
				end
				M_CRC_LO: begin
					if (link.q_ready) begin
						state_q <= M_CRC_HI;
					end
				end
				M_CRC_HI: begin
					if (link.q_ready) begin
						crc_q <= mb_pkg::CRC_INIT;
						state_q <= M_IDLE;
					end
				end
				default: state_q <= M_IDLE;
			endcase
		end
	end

	// Flags a query that breaks the master-side framing limits
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			idx_q <= 4'h0;
			addr_q <= 8'h00;
			fc_q <= 8'h00;
			cnt_q <= 16'h0000;
			o_query_bad <= 1'b0;
		end else if (state_q == M_SEND && link.q_ready) begin
			idx_q <= last_q ? 4'h0 : ((idx_q == 4'hF) ? idx_q : idx_q + 4'h1);
			case (idx_q)
				4'h0: begin
					addr_q <= data_q;
					o_query_bad <= 1'b0;
				end
				4'h1: begin
					fc_q <= data_q;
					if (data_q == mb_pkg::FC_DIAG || data_q == mb_pkg::FC_LOG)
						o_query_bad <= (addr_q == mb_pkg::BCAST_ADDR);
				end
				4'h2, 4'h3: begin
					if (fc_q == mb_pkg::FC_DIAG && data_q != 8'h00)
						o_query_bad <= 1'b1;
				end
				4'h4: cnt_q[15:8] <= data_q;
				4'h5: cnt_q[7:0] <= data_q;
				4'h6: begin
					if (fc_q == mb_pkg::FC_WRMULTI &&
						(cnt_q > mb_pkg::MAX_REGS ||
						{8'h00, data_q} != {cnt_q[14:0], 1'b0} ||
						data_q < mb_pkg::BC_MIN || data_q > mb_pkg::BC_MAX))
						o_query_bad <= 1'b1;
				end
				default: ;
			endcase
			// Any byte after the function code is too many for a log query
			if (idx_q >= 4'h2 && fc_q == mb_pkg::FC_LOG)
				o_query_bad <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
			o_rx_last <= 1'b0;
			o_rx_crc_ok <= 1'b0;
			rcrc_q <= mb_pkg::CRC_INIT;
		end else begin
			o_rx_valid <= link.r_valid;
			o_rx_last <= link.r_valid && link.r_last;
			o_rx_crc_ok <= 1'b0;
			if (link.r_valid) begin
				o_rx_data <= link.r_data;
				rcrc_q <= link.r_last ? mb_pkg::CRC_INIT :
					mb_pkg::crc_step(rcrc_q, link.r_data);
				if (link.r_last)
					o_rx_crc_ok <= (mb_pkg::crc_step(rcrc_q, link.r_data) ==
						16'h0000);
			end
		end
	end

endmodule // mb_master_end
`default_nettype wire

/* File: src/mb_slave_end.sv */
// Overview of operation
// - Diagnostic query: code 08, subfunction 0000, data.
// - Valid diagnostic query echoed byte for byte.
// - Diagnostic and log queries need nonzero address.
// - Write query field order fixed.
// - Write to address 0 is broadcast.
// - Register number is start address plus 40001.
// - Write count at most 125 registers.
// - Byte count twice register count, 02 to FA.
// - Write words high byte first, ascending.
// - Write reply echoes header, fresh check bytes.
// - Log query is address, 46, check bytes.
// - Log holds last read/write start and count; code logs writes only, reads get exception 01.
// - Other previous function logs zero.
// - Logged start is wire address, minus 40001.
// - Log reply: address, 46, start, count, check.
// - No reply to broadcast queries.
// - Error reply: code plus 80, exception code.
`timescale 1ns/1ps
`default_nettype none
module mb_slave_end #(
	parameter int BUF_DEPTH = 264
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	mb_link_if.slave_mp link,
	input wire logic [7:0] i_slave_addr,
	output logic o_wr_valid,
	output logic [16:0] o_wr_reg,
	output logic [15:0] o_wr_data,
	input wire logic i_wr_ok
);

	typedef enum logic [2:0] {
		S_RX = 3'b000,
		S_DEC = 3'b001,
		S_WR = 3'b010,
		S_TX = 3'b011
	} sstate_t;

	sstate_t state_q;
	logic [7:0] buf_q [BUF_DEPTH];
	logic [8:0] rx_idx_q;
	logic [8:0] len_q;
	logic [15:0] crc_q;
	logic crc_ok_q;
	logic [7:0] body_q [6];
	logic [2:0] tx_n_q;
	logic [3:0] tx_i_q;
	logic [15:0] tcrc_q;
	logic [6:0] wr_i_q;
	logic [7:0] ok_cnt_q;
	logic [15:0] ok_start_q;
	logic ok_seen_q;
	logic [15:0] log_start_q;
	logic [15:0] log_cnt_q;

	logic [7:0] addr;
	logic [7:0] fc;
	logic [15:0] start;
	logic [15:0] cnt;
	logic [7:0] bc;
	logic [15:0] wire_addr;
	logic wr_done;
	logic ok_any;
	logic [7:0] ok_cnt_d;
	logic [15:0] ok_start_d;

	assign addr = buf_q[0];
	assign fc = buf_q[1];
	assign start = {buf_q[2], buf_q[3]};
	assign cnt = {buf_q[4], buf_q[5]};
	assign bc = buf_q[6];
	assign wire_addr = start + {9'h000, wr_i_q};
	assign wr_done = ({9'h000, wr_i_q} == cnt - 16'h0001);
	assign ok_any = ok_seen_q || i_wr_ok;
	assign ok_cnt_d = ok_cnt_q + {7'h00, i_wr_ok};
	assign ok_start_d = ok_seen_q ? ok_start_q : wire_addr;

	assign link.q_ready = (state_q == S_RX);
	assign link.r_valid = (state_q == S_TX);
	assign link.r_data = (tx_i_q < {1'b0, tx_n_q}) ? body_q[tx_i_q[2:0]] :
		(tx_i_q == {1'b0, tx_n_q}) ? tcrc_q[7:0] : tcrc_q[15:8];
	assign link.r_last = (tx_i_q == {1'b0, tx_n_q} + 4'h1);

	assign o_wr_valid = (state_q == S_WR);
	assign o_wr_reg = {1'b0, wire_addr} + mb_pkg::REG_BASE;
	assign o_wr_data = {buf_q[7 + 2 * wr_i_q], buf_q[8 + 2 * wr_i_q]};

	// Frame capture with running check
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rx_idx_q <= 9'h000;
			len_q <= 9'h000;
			crc_q <= mb_pkg::CRC_INIT;
			crc_ok_q <= 1'b0;
		end else if (state_q == S_RX && link.q_valid) begin
			if (rx_idx_q < 9'(BUF_DEPTH))
				buf_q[rx_idx_q] <= link.q_data;
			if (rx_idx_q != 9'h1FF)
				rx_idx_q <= rx_idx_q + 9'h001;
			crc_q <= mb_pkg::crc_step(crc_q, link.q_data);
			if (link.q_last) begin
				rx_idx_q <= 9'h000;
				crc_q <= mb_pkg::CRC_INIT;
				len_q <= rx_idx_q + 9'h001;
				crc_ok_q <= (mb_pkg::crc_step(crc_q, link.q_data) ==
					16'h0000) && (rx_idx_q < 9'(BUF_DEPTH));
			end
		end
	end

	// Decode, execute and reply sequencing
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_q <= S_RX;
			tx_n_q <= 3'h0;
			tx_i_q <= 4'h0;
			tcrc_q <= mb_pkg::CRC_INIT;
			wr_i_q <= 7'h00;
			ok_cnt_q <= 8'h00;
			ok_start_q <= 16'h0000;
			ok_seen_q <= 1'b0;
			log_start_q <= 16'h0000;
			log_cnt_q <= 16'h0000;
			for (int i = 0; i < 6; i++)
				body_q[i] <= 8'h00;
		end else begin
			case (state_q)
				S_RX: begin
					if (link.q_valid && link.q_last)
						state_q <= S_DEC;
				end
				S_DEC: begin
					tx_i_q <= 4'h0;
					tcrc_q <= mb_pkg::CRC_INIT;
					state_q <= S_RX;
					body_q[0] <= addr;
					body_q[1] <= fc | mb_pkg::EXC_FLAG;
					body_q[2] <= mb_pkg::EXC_FUNC;
					tx_n_q <= mb_pkg::EXC_LEN;
					if (!crc_ok_q || len_q < mb_pkg::MIN_FRAME ||
						(addr != i_slave_addr &&
						addr != mb_pkg::BCAST_ADDR)) begin
						state_q <= S_RX;
					end else if (fc == mb_pkg::FC_LOG) begin
						if (addr != mb_pkg::BCAST_ADDR) begin
							state_q <= S_TX;
							if (len_q != mb_pkg::LOG_LEN) begin
								body_q[2] <= mb_pkg::EXC_DATA;
							end else begin
								body_q[1] <= mb_pkg::FC_LOG;
								body_q[2] <= log_start_q[15:8];
								body_q[3] <= log_start_q[7:0];
								body_q[4] <= log_cnt_q[15:8];
								body_q[5] <= log_cnt_q[7:0];
								tx_n_q <= mb_pkg::BODY_LEN;
							end
						end
					end else if (fc == mb_pkg::FC_WRMULTI) begin
						log_start_q <= 16'h0000;
						log_cnt_q <= 16'h0000;
						if (len_q != mb_pkg::WR_HDR_LEN + {1'b0, bc} ||
							cnt == 16'h0000 || cnt > mb_pkg::MAX_REGS ||
							bc < mb_pkg::BC_MIN || bc > mb_pkg::BC_MAX ||
							{8'h00, bc} != {cnt[14:0], 1'b0}) begin
							body_q[2] <= mb_pkg::EXC_DATA;
							if (addr != mb_pkg::BCAST_ADDR)
								state_q <= S_TX;
						end else begin
							state_q <= S_WR;
							wr_i_q <= 7'h00;
							ok_cnt_q <= 8'h00;
							ok_seen_q <= 1'b0;
						end
					end else begin
						log_start_q <= 16'h0000;
						log_cnt_q <= 16'h0000;
						if (addr != mb_pkg::BCAST_ADDR) begin
							state_q <= S_TX;
							if (fc != mb_pkg::FC_DIAG) begin
								body_q[2] <= mb_pkg::EXC_FUNC;
							end else if (len_q != mb_pkg::DIAG_LEN ||
								start != mb_pkg::SUB_ECHO) begin
								body_q[2] <= mb_pkg::EXC_DATA;
							end else begin
								for (int i = 0; i < 6; i++)
									body_q[i] <= buf_q[i];
								tx_n_q <= mb_pkg::BODY_LEN;
							end
						end
					end
				end
				S_WR: begin
					wr_i_q <= wr_i_q + 7'h01;
					ok_cnt_q <= ok_cnt_d;
					ok_start_q <= ok_start_d;
					ok_seen_q <= ok_any;
					if (wr_done) begin
						state_q <= (addr == mb_pkg::BCAST_ADDR) ? S_RX : S_TX;
						if (ok_any) begin
							log_start_q <= ok_start_d;
							log_cnt_q <= {8'h00, ok_cnt_d};
							for (int i = 0; i < 6; i++)
								body_q[i] <= buf_q[i];
							tx_n_q <= mb_pkg::BODY_LEN;
						end else begin
							body_q[2] <= mb_pkg::EXC_ADDR;
						end
					end
				end
				S_TX: begin
					if (link.r_ready) begin
						tx_i_q <= tx_i_q + 4'h1;
						if (tx_i_q < {1'b0, tx_n_q})
							tcrc_q <= mb_pkg::crc_step(tcrc_q, link.r_data);
						if (link.r_last)
							state_q <= S_RX;
					end
				end
				default: state_q <= S_RX;
			endcase
		end
	end

endmodule // mb_slave_end
`default_nettype wire

/* File: bench/mb_link_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mb_link_assertions (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic q_valid,
	input wire logic [7:0] q_data,
	input wire logic q_last,
	input wire logic q_ready,
	input wire logic r_valid,
	input wire logic [7:0] r_data,
	input wire logic r_last,
	input wire logic r_ready
);
	logic [7:0] qb_q [8];
	logic [8:0] qn_q, qlen_q;
	logic [3:0] rn_q;
	logic [7:0] rfc_q;
	logic q_acc, r_acc, echo;
	assign q_acc = q_valid && q_ready;
	assign r_acc = r_valid && r_ready;
	assign echo = qlen_q == 9'h008 && qb_q[1] == 8'h08
		&& qb_q[2] == 8'h00 && qb_q[3] == 8'h00;

	// Latest query: first eight bytes and total length
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			qn_q <= 9'h000;
			qlen_q <= 9'h000;
		end else if (q_acc) begin
			qn_q <= q_last ? 9'h000 : qn_q + 9'h001;
			qlen_q <= qn_q + 9'h001;
		end
	end
	always_ff @(posedge i_ref_clk)
		if (q_acc && qn_q < 9'h008)
			qb_q[qn_q[2:0]] <= q_data;
	// Reply byte index and reply function byte
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			rn_q <= 4'h0;
		else if (r_acc)
			rn_q <= r_last ? 4'h0 : rn_q + 4'h1;
	end
	always_ff @(posedge i_ref_clk)
		if (r_acc && rn_q == 4'h1)
			rfc_q <= r_data;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	addr_echo_a: assert property (
		r_valid && rn_q == 4'h0 |-> r_data == qb_q[0])
		else $error("reply address differs");
	diag_echo_a: assert property (
		r_valid && echo && rn_q < 4'h8 |-> r_data == qb_q[rn_q[2:0]])
		else $error("diagnostic reply not an echo");
	wr_echo_a: assert property (
		r_valid && qb_q[1] == 8'h10 && rfc_q == 8'h10 && rn_q > 4'h1
		&& rn_q < 4'h6 |-> r_data == qb_q[rn_q[2:0]])
		else $error("write reply header differs");
	func_byte_a: assert property (
		r_valid && rn_q == 4'h1
		|-> r_data == qb_q[1] || r_data == (qb_q[1] | 8'h80))
		else $error("reply function byte wrong");
	exc_code_a: assert property (
		r_valid && rn_q == 4'h2 && rfc_q[7]
		|-> r_data inside {8'h01, 8'h02, 8'h03})
		else $error("exception code out of range");
	exc_len_a: assert property (
		r_acc && rfc_q[7] && rn_q > 4'h1 |-> r_last == (rn_q == 4'h4))
		else $error("exception reply length wrong");
	reply_len_a: assert property (
		r_acc && r_last |-> rn_q == 4'h4 || rn_q == 4'h7)
		else $error("reply length wrong");
	no_bcast_a: assert property (
		r_valid |-> qb_q[0] != 8'h00)
		else $error("reply to broadcast");
	log_count_a: assert property (
		r_valid && rfc_q == 8'h46 && rn_q == 4'h4 |-> r_data == 8'h00)
		else $error("logged count above limit");
	reply_end_a: assert property (
		$fell(r_valid) |-> $past(r_last))
		else $error("reply cut short");
endmodule // mb_link_assertions
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_tx_valid = 1'b0;
	logic [7:0] i_tx_data = 8'h00;
	logic i_tx_last = 1'b0;
	logic [7:0] i_slave_addr = 8'h05;
	logic [15:0] ok_pat = 16'hFFFF;
	logic [3:0] wcnt = 4'h0;
	logic i_wr_ok, o_tx_ready, o_query_bad, o_rx_valid, o_rx_last;
	logic o_rx_crc_ok, o_wr_valid, rx_end, crc_ok;
	logic [7:0] o_rx_data;
	logic [16:0] o_wr_reg;
	logic [15:0] o_wr_data;
	logic [7:0] rx_q[$];
	logic [32:0] wr_q[$];
	int n_mismatch = 0;
	int samples_checked = 0;

	mb_link_if link ();
	mb_master_end mb_master_end_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.link(link), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
		.i_tx_last(i_tx_last), .o_tx_ready(o_tx_ready),
		.o_query_bad(o_query_bad), .o_rx_valid(o_rx_valid),
		.o_rx_data(o_rx_data), .o_rx_last(o_rx_last),
		.o_rx_crc_ok(o_rx_crc_ok));
	mb_slave_end mb_slave_end_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.link(link), .i_slave_addr(i_slave_addr), .o_wr_valid(o_wr_valid),
		.o_wr_reg(o_wr_reg), .o_wr_data(o_wr_data), .i_wr_ok(i_wr_ok));
	mb_link_assertions mb_link_assertions_inst (.i_ref_clk(i_ref_clk),
		.i_rst(i_rst), .q_valid(link.q_valid), .q_data(link.q_data),
		.q_last(link.q_last), .q_ready(link.q_ready),
		.r_valid(link.r_valid), .r_data(link.r_data),
		.r_last(link.r_last), .r_ready(link.r_ready));

	always #10 i_ref_clk = ~i_ref_clk;
	assign i_wr_ok = ok_pat[wcnt];

	// Collect reply bytes and register writes
	always @(posedge i_ref_clk) begin
		if (o_rx_valid === 1'b1) begin
			rx_q.push_back(o_rx_data);
			rx_end = o_rx_last;
			crc_ok = o_rx_crc_ok;
		end
		if (o_wr_valid === 1'b1) begin
			wr_q.push_back({o_wr_reg, o_wr_data});
			wcnt <= wcnt + 4'h1;
		end
	end

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic hang();
		n_mismatch++;
		wrap_up();
	endtask

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(posedge i_ref_clk);
		#1;
	endtask

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction

	// Send a query body, then compare the whole reply with its check bytes
	task automatic xact(input int nq, input logic [103:0] q,
		input int nr, input logic [47:0] r);
		logic [7:0] e[$];
		logic [15:0] c;
		rx_q = {};
		rx_end = 1'b0;
		for (int i = nq - 1; i >= 0; i--) begin
			i_tx_valid = 1'b1;
			i_tx_data = q[8*i +: 8];
			i_tx_last = i == 0;
			for (int n = 0; n < 99 && o_tx_ready !== 1'b1; n++)
				tick();
			if (o_tx_ready !== 1'b1)
				hang();
			tick();
		end
		i_tx_valid = 1'b0;
		i_tx_last = 1'b0;
		for (int n = 0; n < 600 && !rx_end; n++)
			tick();
		if (nr > 0 && !rx_end)
			hang();
		for (int i = nr - 1; i >= 0; i--)
			e.push_back(r[8*i +: 8]);
		c = crc16(e);
		if (nr > 0) begin
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
			check(crc_ok, 1'h1);
		end
		check(rx_q.size(), e.size());
		foreach (e[i])
			check(rx_q[i], e[i]);
	endtask

	task automatic t_diag();
		logic [15:0] d[3] = '{16'h0000, 16'hFFFF, 16'hA55A};
		foreach (d[i]) begin
			xact(6, {24'h050800, 8'h00, d[i]}, 6, {24'h050800, 8'h00, d[i]});
			check(o_query_bad, 1'h0);
		end
		xact(6, 48'h0508_0001_0000, 3, 24'h058803);
		check(o_query_bad, 1'h1);
		$display("diag test done");
	endtask

	task automatic t_write();
		wr_q = {};
		wcnt = 4'h0;
		xact(11, 88'h0510_03EE_0002_04_0005_000A,
			6, 48'h0510_03EE_0002);
		check(wr_q.size(), 2);
		check(wr_q[0], {17'h003EE + 17'h09C41, 16'h0005});
		check(wr_q[1], {17'h003EF + 17'h09C41, 16'h000A});
		$display("write test done");
	endtask

	task automatic t_log();
		ok_pat = 16'h0006;
		wcnt = 4'h0;
		xact(13, 104'h0510_0010_0003_06_1111_2222_3333,
			6, 48'h0510_0010_0003);
		xact(2, 16'h0546, 6, 48'h0546_0011_0002);
		xact(6, 48'h0508_0000_0000, 6, 48'h0508_0000_0000);
		xact(2, 16'h0546, 6, 48'h0546_0000_0000);
		ok_pat = 16'h0000;
		xact(9, 72'h0510_0020_0001_02_ABCD, 3, 24'h059002);
		ok_pat = 16'hFFFF;
		$display("log test done");
	endtask

	task automatic t_bcast();
		wr_q = {};
		wcnt = 4'h0;
		xact(9, 72'h0010_0001_0001_02_1234, 0, 48'h0);
		check(wr_q.size(), 1);
		check(wr_q[0], {17'h00001 + 17'h09C41, 16'h1234});
		xact(6, 48'h0008_0000_1234, 0, 48'h0);
		check(o_query_bad, 1'h1);
		$display("broadcast test done");
	endtask

	task automatic t_errors();
		xact(2, 16'h0507, 3, 24'h058701);
		xact(10, 80'h0510_0000_0002_03_000102, 3, 24'h059003);
		check(o_query_bad, 1'h1);
		xact(7, 56'h0510_0000_007E_FC, 3, 24'h059003);
		check(o_query_bad, 1'h1);
		xact(3, 24'h054600, 3, 24'h05C603);
		check(o_query_bad, 1'h1);
		xact(1, 8'h05, 0, 48'h0);
		xact(6, 48'h0608_0000_0000, 0, 48'h0);
		$display("error test done");
	endtask

	initial begin
		repeat (4) @(posedge i_ref_clk);
		#1;
		i_rst = 1'b0;
		t_diag();
		t_write();
		t_log();
		t_bcast();
		t_errors();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
